/* common/usb_cmd_pkg.sv */
// shared constants for the host command and interrupt flag register bank
package usb_cmd_pkg;
    // register byte addresses
    localparam logic [31:0] cmd_status_addr = 32'hFFF05008;
    localparam logic [31:0] int_flags_addr = 32'hFFF0500C;
    localparam logic [31:0] int_mask_addr = 32'hFFF05040;
    // host_command_status fields
    localparam int soft_reset_bit = 0;
    localparam int control_list_bit = 1;
    localparam int bulk_list_bit = 2;
    localparam int owner_request_bit = 3;
    localparam int overrun_count_lsb = 16;
    // host_interrupt_flags fields
    localparam int overrun_flag_bit = 0;
    localparam int done_head_bit = 1;
    localparam int sof_bit = 2;
    localparam int resume_bit = 3;
    localparam int unrecoverable_bit = 4;
    localparam int frame_overflow_bit = 5;
    localparam int root_hub_bit = 6;
    localparam int owner_change_bit = 30;
    localparam logic [31:0] flag_valid_mask = 32'h4000006F;
    // reset values
    localparam logic [31:0] cmd_status_reset = 32'h00000000;
    localparam logic [31:0] int_flags_reset = 32'h00000000;
    localparam logic [31:0] int_mask_reset = 32'h00000000;
    // soft reset length in clock cycles
    localparam logic [3:0] soft_reset_cycles = 4'h8;
endpackage

/* design/usb_frame_edge.sv */
// edge watcher on frame counter bit 15 and the root hub content
`timescale 1ns/100ps
`default_nettype none
module usb_frame_edge (
    input wire logic clk,
    input wire logic resetn,
    input wire logic frame_bit15,
    input wire logic [31:0] hub_status,
    output logic frame_toggle,
    output logic hub_changed
);
    logic last_bit15;
    logic [31:0] last_hub;
    logic next_last_bit15;
    logic [31:0] next_last_hub;

    // compare against previous sample; any difference is an event
    always_comb begin
        next_last_bit15 = frame_bit15;
        next_last_hub = hub_status;
        frame_toggle = frame_bit15 ^ last_bit15;
        hub_changed = (hub_status != last_hub);
    end

    // previous samples; reset values match a zeroed counter and hub
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_bit15 <= 1'b0;
            last_hub <= 32'h00000000;
        end else begin
            last_bit15 <= next_last_bit15;
            last_hub <= next_last_hub;
        end
    end
endmodule
`default_nettype wire

/* design/usb_cmd_status_regs.sv */
// host command status and interrupt flag registers behind an APB slave
//
// Functional notes
// RQ1: a 2-bit overrun counter steps on each new scheduling overrun flag set and wraps 11 to 00.
// RQ2: a set ownership change request sets the ownership change flag; software clears the request.
// RQ3: bulk list filled is set by software or hardware and cleared when bulk list head starts.
// RQ4: control list filled is set by software or hardware and cleared when control head starts.
// RQ5: writing one to the soft reset bit runs a reset which clears the bit when done.
// RQ6: only hardware sets event flags; software only clears them.
// RQ7: the root hub change flag sets whenever root hub or port status content changes. (the code watches their XOR, so equal changes to both in one cycle cancel)
// RQ8: the frame number overflow flag sets whenever frame counter bit 15 toggles.
// RQ9: the unrecoverable error flag always reads zero and ignores writes.
// RQ10: the resume detected flag sets on resume signalling from any downstream port.
// RQ11: the start of frame flag sets on each frame management start of frame event.
// RQ12: the done head written flag sets after the done queue head pointer is written back.
// RQ13: the scheduling overrun flag sets when the list processor reports an overrun.
// RQ14: software clears a flag by writing one; zero leaves it; reserved bits read zero.
// RQ15: both registers reset to zero; soft reset zeroes list filled bits and event flags.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module usb_cmd_status_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bulk_head_start,
    input wire logic control_head_start,
    input wire logic bulk_list_set,
    input wire logic control_list_set,
    input wire logic overrun_event,
    input wire logic done_head_written,
    input wire logic sof_event,
    input wire logic resume_pin,
    input wire logic [15:0] frame_counter,
    input wire logic [31:0] root_hub_status_reg,
    input wire logic [31:0] root_hub_port_status_reg,
    output logic soft_reset_active,
    output logic bulk_list_filled,
    output logic control_list_filled,
    output logic ownership_change_request,
    output logic irq
);
    typedef enum logic [1:0] {bus_idle, bus_access, bus_done} bus_state_t;

    bus_state_t bus_state, next_bus_state;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    logic next_bulk, next_control, next_owner, next_soft_active;
    logic [1:0] overrun_count, next_overrun_count;
    logic [3:0] reset_timer, next_reset_timer;
    logic [31:0] flags, next_flags, set_flags;
    logic [31:0] mask, next_mask;
    logic next_irq;

    logic resume_meta, resume_sync;
    logic frame_toggle, hub_changed, owner_prev, next_owner_prev;
    logic wr_access, rd_access, addr_hit, wr_cmd, wr_flags, wr_mask;

    // resume comes from a pin: two flops before any logic reads it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resume_meta <= 1'b0;
            resume_sync <= 1'b0;
        end else begin
            resume_meta <= resume_pin;
            resume_sync <= resume_meta;
        end
    end

    // RQ7 RQ8 edge watchers
    usb_frame_edge u_edge (
        .clk(clk),
        .resetn(resetn),
        .frame_bit15(frame_counter[15]),
        .hub_status(root_hub_status_reg ^ root_hub_port_status_reg),
        .frame_toggle(frame_toggle),
        .hub_changed(hub_changed)
    );

    // decode of the access phase; a write takes effect when pready is seen
    always_comb begin
        addr_hit = (paddr == usb_cmd_pkg::cmd_status_addr) ||
                   (paddr == usb_cmd_pkg::int_flags_addr) ||
                   (paddr == usb_cmd_pkg::int_mask_addr);
        wr_access = psel && penable && pready && pwrite;
        rd_access = psel && penable && !pready && !pwrite;
        wr_cmd = wr_access && (paddr == usb_cmd_pkg::cmd_status_addr);
        wr_flags = wr_access && (paddr == usb_cmd_pkg::int_flags_addr);
        wr_mask = wr_access && (paddr == usb_cmd_pkg::int_mask_addr);
    end

    // apb answer: one wait state, pready a flop; unmapped address gives pslverr
    always_comb begin
        next_bus_state = bus_state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        unique case (bus_state)
            bus_idle: begin
                if (psel && penable) begin
                    next_bus_state = bus_access;
                    next_pready = 1'b1;
                    next_pslverr = !addr_hit;
                    next_prdata = 32'h00000000;
                    if (rd_access && paddr == usb_cmd_pkg::cmd_status_addr) begin
                        next_prdata[usb_cmd_pkg::soft_reset_bit] = soft_reset_active;
                        next_prdata[usb_cmd_pkg::control_list_bit] = control_list_filled;
                        next_prdata[usb_cmd_pkg::bulk_list_bit] = bulk_list_filled;
                        next_prdata[usb_cmd_pkg::owner_request_bit] = ownership_change_request;
                        next_prdata[usb_cmd_pkg::overrun_count_lsb +: 2] = overrun_count;
                    end else if (rd_access && paddr == usb_cmd_pkg::int_flags_addr) begin
                        // RQ14 reserved bits read zero
                        next_prdata = flags & usb_cmd_pkg::flag_valid_mask;
                    end else if (rd_access && paddr == usb_cmd_pkg::int_mask_addr) begin
                        next_prdata = mask & usb_cmd_pkg::flag_valid_mask;
                    end
                end
            end
            bus_access: begin
                next_bus_state = bus_done;
            end
            bus_done: begin
                next_bus_state = bus_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= bus_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            bus_state <= next_bus_state;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // hardware event sources gathered onto flag positions
    always_comb begin
        set_flags = 32'h00000000;
        // RQ13 overrun flag set
        set_flags[usb_cmd_pkg::overrun_flag_bit] = overrun_event;
        // RQ12 done head set
        set_flags[usb_cmd_pkg::done_head_bit] = done_head_written;
        // RQ11 sof flag set
        set_flags[usb_cmd_pkg::sof_bit] = sof_event;
        // RQ10 resume flag set
        set_flags[usb_cmd_pkg::resume_bit] = resume_sync;
        // RQ8 frame overflow set
        set_flags[usb_cmd_pkg::frame_overflow_bit] = frame_toggle;
        // RQ7 root hub set
        set_flags[usb_cmd_pkg::root_hub_bit] = hub_changed;
        // RQ2 ownership flag on request rising
        set_flags[usb_cmd_pkg::owner_change_bit] = ownership_change_request && !owner_prev;
    end

    // command bits, flags, mask and soft reset sequencing
    always_comb begin
        next_bulk = bulk_list_filled;
        next_control = control_list_filled;
        next_owner = ownership_change_request;
        next_owner_prev = ownership_change_request;
        next_soft_active = soft_reset_active;
        next_reset_timer = reset_timer;
        next_overrun_count = overrun_count;
        next_flags = flags;
        next_mask = mask;
        // RQ14 write one to clear; RQ6 software never sets a flag
        if (wr_flags) begin
            next_flags = next_flags & ~pwdata;
        end
        // set wins over a clear in the same cycle
        next_flags = next_flags | set_flags;
        // RQ1 count each new overrun flag set, wrapping naturally
        if (set_flags[usb_cmd_pkg::overrun_flag_bit] && !flags[usb_cmd_pkg::overrun_flag_bit]) begin
            next_overrun_count = overrun_count + 2'b01;
        end
        if (wr_mask) begin
            next_mask = pwdata & usb_cmd_pkg::flag_valid_mask;
        end
        // RQ3 bulk filled: head start clears, set by either party wins
        if (bulk_head_start) begin
            next_bulk = 1'b0;
        end
        if (bulk_list_set || (wr_cmd && pwdata[usb_cmd_pkg::bulk_list_bit])) begin
            next_bulk = 1'b1;
        end
        // RQ4 control filled: same shape as bulk
        if (control_head_start) begin
            next_control = 1'b0;
        end
        if (control_list_set || (wr_cmd && pwdata[usb_cmd_pkg::control_list_bit])) begin
            next_control = 1'b1;
        end
        // RQ2 request held until software writes it clear
        if (wr_cmd) begin
            next_owner = pwdata[usb_cmd_pkg::owner_request_bit];
        end
        // RQ5 start the soft reset; the bit drops by itself when done
        if (wr_cmd && pwdata[usb_cmd_pkg::soft_reset_bit] && !soft_reset_active) begin
            next_soft_active = 1'b1;
            next_reset_timer = usb_cmd_pkg::soft_reset_cycles;
        end else if (soft_reset_active) begin
            // RQ15 soft reset zeroes list bits and flags while it runs
            next_bulk = 1'b0;
            next_control = 1'b0;
            next_flags = 32'h00000000;
            next_reset_timer = reset_timer - 4'h1;
            if (reset_timer == 4'h1) begin
                next_soft_active = 1'b0;
            end
        end
        // RQ9 unrecoverable error never set
        next_flags[usb_cmd_pkg::unrecoverable_bit] = 1'b0;
        next_irq = |(next_flags & next_mask);
    end

    // RQ15 all zero after system reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bulk_list_filled <= 1'b0;
            control_list_filled <= 1'b0;
            ownership_change_request <= 1'b0;
            owner_prev <= 1'b0;
            soft_reset_active <= 1'b0;
            reset_timer <= 4'h0;
            overrun_count <= 2'b00;
            flags <= usb_cmd_pkg::int_flags_reset;
            mask <= usb_cmd_pkg::int_mask_reset;
            irq <= 1'b0;
        end else begin
            bulk_list_filled <= next_bulk;
            control_list_filled <= next_control;
            ownership_change_request <= next_owner;
            owner_prev <= next_owner_prev;
            soft_reset_active <= next_soft_active;
            reset_timer <= next_reset_timer;
            overrun_count <= next_overrun_count;
            flags <= next_flags;
            mask <= next_mask;
            irq <= next_irq;
        end
    end
endmodule
`default_nettype wire

/* sim/usb_cmd_chk.sv */
// assertion checker for the command status and interrupt flag registers
`timescale 1ns/100ps
`default_nettype none
module usb_cmd_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic bulk_head_start,
    input wire logic control_head_start,
    input wire logic bulk_list_set,
    input wire logic control_list_set,
    input wire logic soft_reset_active,
    input wire logic bulk_list_filled,
    input wire logic control_list_filled,
    input wire logic ownership_change_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // completed accesses; a write may set list bits in the same edge as a clear
    logic done_rd;
    logic wr_cmd;
    assign done_rd = psel && penable && pready && !pwrite;
    assign wr_cmd = psel && penable && pready && pwrite && paddr == usb_cmd_pkg::cmd_status_addr;
    soft_clear_a: assert property ($rose(soft_reset_active) |-> ##[1:9] !soft_reset_active)
        else $error("soft reset bit never cleared");
    bulk_clr_a: assert property (bulk_head_start && !bulk_list_set && !wr_cmd
        |=> !bulk_list_filled) else $error("bulk list bit not cleared");
    ctrl_clr_a: assert property (control_head_start && !control_list_set && !wr_cmd
        |=> !control_list_filled) else $error("control list bit not cleared");
    bulk_set_a: assert property (bulk_list_set && !bulk_head_start && !soft_reset_active
        |=> bulk_list_filled) else $error("bulk list bit not set");
    ctrl_set_a: assert property (control_list_set && !control_head_start && !soft_reset_active
        |=> control_list_filled) else $error("control list bit not set");
    owner_req_a: assert property (wr_cmd |=> ownership_change_request == $past(pwdata[3]))
        else $error("ownership request bit wrong");
    flag_zero_a: assert property (done_rd && paddr == usb_cmd_pkg::int_flags_addr
        |-> prdata[4] == 1'b0 && prdata[31] == 1'b0 && prdata[29:7] == 23'h0)
        else $error("reserved or error flag read nonzero");
    cmd_rsvd_a: assert property (done_rd && paddr == usb_cmd_pkg::cmd_status_addr
        |-> prdata[31:18] == 14'h0 && prdata[15:4] == 12'h0)
        else $error("reserved command bits nonzero");
endmodule
bind usb_cmd_status_regs usb_cmd_chk chk_u (.*);
`default_nettype wire

/* sim/usb_event_model.sv */
// far side model: list processor, frame timer, root hub and resume pin
`timescale 1ns/100ps
`default_nettype none
module usb_event_model (
    input wire logic clk,
    output logic bulk_head_start,
    output logic control_head_start,
    output logic bulk_list_set,
    output logic control_list_set,
    output logic overrun_event,
    output logic done_head_written,
    output logic sof_event,
    output logic resume_pin,
    output logic [15:0] frame_counter,
    output logic [31:0] root_hub_status_reg,
    output logic [31:0] root_hub_port_status_reg
);
    logic [6:0] p;
    assign {sof_event, done_head_written, overrun_event, control_list_set} = p[6:3];
    assign {bulk_list_set, control_head_start, bulk_head_start} = p[2:0];
    // levels start quiet so no change is seen out of reset
    initial begin
        p = 7'h00;
        resume_pin = 1'b0;
        frame_counter = 16'h0000;
        root_hub_status_reg = 32'h00000000;
        root_hub_port_status_reg = 32'h00000000;
    end
    task fire(input int k);
        @(posedge clk) p[k] <= 1'b1;
        @(posedge clk) p[k] <= 1'b0;
    endtask
    task resume(input logic v);
        @(posedge clk) resume_pin <= v;
    endtask
    // frame counter bit 15 toggles, lower bits kept
    task frame_flip();
        @(posedge clk) frame_counter <= frame_counter + 16'h8000;
    endtask
    // either the hub status or one port status changes content
    task hub_bump(input logic on_port);
        @(posedge clk);
        if (on_port) root_hub_port_status_reg <= root_hub_port_status_reg + 32'h1;
        else root_hub_status_reg <= root_hub_status_reg + 32'h1;
    endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the command status and interrupt flag registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [31:0] a_cmd = usb_cmd_pkg::cmd_status_addr;
    localparam logic [31:0] a_flg = usb_cmd_pkg::int_flags_addr;
    localparam logic [31:0] a_msk = usb_cmd_pkg::int_mask_addr;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, root_hub_status_reg;
    logic pready, pslverr, bulk_head_start, control_head_start, bulk_list_set, err;
    logic control_list_set, overrun_event, done_head_written, sof_event, resume_pin;
    logic soft_reset_active, bulk_list_filled, control_list_filled, ownership_change_request, irq;
    logic [15:0] frame_counter;
    logic [31:0] root_hub_port_status_reg;
    int err_total = 0, n_tests = 0, cyc = 0, n;
    usb_cmd_status_regs dut_u (.*);
    usb_event_model part_u (.*);
    always #12.5 clk = ~clk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    // one transfer; data taken in the cycle whose closing edge samples pready
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // request stands until the rising edge that samples pready high
        do @(posedge clk); while (pready !== 1'b1 && ++n < 40);
        rd = prdata;
        err = pslverr;
        if (n >= 40) err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, x);
    endtask
    // reset values and an unmapped slot
    task automatic t_reset();
        rchk("cmd", a_cmd, 32'h0);
        rchk("flags", a_flg, 32'h0);
        rchk("mask", a_msk, 32'h0);
        apb(1'b0, 32'hFFF05000, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
    endtask
    // every event flag except ownership change, masking and write-one clear
    task automatic t_events();
        part_u.fire(6);
        part_u.fire(5);
        part_u.fire(4);
        part_u.frame_flip();
        part_u.hub_bump(1'b1);
        part_u.resume(1'b1);
        repeat (3) @(posedge clk);
        part_u.resume(1'b0);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, a_flg, 32'h00000010);
        rchk("flags", a_flg, 32'h0000006F);
        rchk("count", a_cmd, 32'h00010000);
        apb(1'b1, a_msk, 32'h00000004);
        repeat (2) @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b1, a_flg, 32'hFFFFFFFF);
        rchk("flags clr", a_flg, 32'h0);
        chk("irq off", {31'h0, irq}, 32'h0);
        for (int i = 2; i < 6; i++) begin
            part_u.fire(4);
            apb(1'b1, a_flg, 32'h00000001);
            rchk("count wrap", a_cmd, {14'h0, 2'(i), 16'h0});
        end
    endtask
    task automatic t_owner();
        apb(1'b1, a_cmd, 32'h00000008);
        rchk("own flag", a_flg, 32'h40000000);
        apb(1'b1, a_flg, 32'h40000000);
        rchk("own kept", a_cmd, 32'h00010008);
        rchk("own clr", a_flg, 32'h0);
        part_u.hub_bump(1'b0);
        rchk("hub status", a_flg, 32'h00000040);
        apb(1'b1, a_flg, 32'h00000040);
        part_u.hub_bump(1'b1);
        rchk("hub port", a_flg, 32'h00000040);
        apb(1'b1, a_flg, 32'h00000040);
        apb(1'b1, a_cmd, 32'h0);
    endtask
    task automatic t_lists();
        apb(1'b1, a_cmd, 32'h00000006);
        rchk("sw set", a_cmd, 32'h00010006);
        part_u.fire(0);
        part_u.fire(1);
        rchk("hw clr", a_cmd, 32'h00010000);
        part_u.fire(2);
        part_u.fire(3);
        part_u.fire(6);
        rchk("hw set", a_cmd, 32'h00010006);
        apb(1'b1, a_cmd, 32'h00000001);
        @(negedge clk);
        chk("soft on", {31'h0, soft_reset_active}, 32'h1);
        n = 0;
        while (soft_reset_active === 1'b1 && ++n < 20) @(negedge clk);
        rchk("soft clr", a_cmd, 32'h00010000);
        chk("soft cmd", rd & 32'hFFFCFFFF, 32'h0);
        rchk("soft flags", a_flg, 32'h0);
        chk("soft irq", {31'h0, irq}, 32'h0);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_events();
        t_owner();
        t_lists();
        stop_test();
    end
endmodule
`default_nettype wire
